/* rtl/rx_pohm_pkg.sv */
/*
  Constants, reset values and carrier types for the receive path trace and
  path BIP-8 monitor. Assumes one 50 MHz system clock.
*/
`default_nettype none
package rx_pohm_pkg;
  localparam int NCH = 4;
  localparam logic [15:0] A_ACC_CTL  = 16'h4100;
  localparam logic [15:0] A_ACC_DONE = 16'h4101;
  localparam logic [15:0] A_ACC_GO   = 16'h4102;
  localparam logic [15:0] A_BUF      = 16'h4110;
  localparam logic [15:0] A_TRC_CTL  = 16'h4406;
  localparam logic [15:0] A_MAINT    = 16'h4407;
  localparam logic [15:0] A_CV       = 16'h4408;
  localparam logic [15:0] A_ALARM    = 16'h4413;
  localparam logic [15:0] CH_STRIDE  = 16'h0100;
  localparam logic [15:0] A_SF_SET   = 16'h4002;
  localparam logic [15:0] A_WIN      = 16'h4012;
  localparam logic [15:0] ACC_GO     = 16'h0001;
  localparam logic [5:0]  LAST_SONET = 6'h3F;
  localparam logic [5:0]  LAST_SDH   = 6'h0F;
  localparam logic [7:0]  CHR_CR     = 8'h0D;
  localparam logic [7:0]  CHR_LF     = 8'h0A;
  localparam logic [3:0]  MISM_CNT   = 4'hA;
  localparam logic [3:0]  NEW_CNT    = 4'hA;
  localparam logic [2:0]  CLR_WIN    = 3'h5;
  localparam logic [2:0]  CLR_MATCH  = 3'h4;
  localparam int HALF_MS_NS  = 500000;
  localparam int CLK_NS      = 20;
  localparam int HALF_MS_CYC = (HALF_MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [13:0] SF9_MAX  = 14'h01FF;
  localparam logic [13:0] SF14_MAX = 14'h3FFF;
  localparam logic [15:0] CV_MAX   = 16'hFFFF;
  localparam int TC_SDH = 6;
  localparam int TC_VAL = 7;
  localparam int TC_MSK = 8;
  localparam int MT_BLK = 0;
  localparam int MT_SET = 1;
  localparam int MT_SD  = 4;
  localparam int AC_KIND = 2;
  localparam int AC_WR   = 3;
  localparam logic [15:0] SF_THR_RST [8][2] = '{
    '{16'h40CF, 16'h8113}, '{16'h80DE, 16'hC115}, '{16'h4233, 16'h830B}, '{16'h82B2, 16'hC31B},
    '{16'h43A3, 16'h85D8}, '{16'h855E, 16'hC618}, '{16'h451D, 16'h8B08}, '{16'h8A62, 16'hCBFC}};
  localparam logic [15:0] WIN_RST [4] = '{16'h000A, 16'h0064, 16'h03E8, 16'h2710};

  typedef enum logic [1:0] {DC_NONE = 2'b00, DC_SD = 2'b01, DC_SF = 2'b11} drop_code_type;
  typedef enum logic [1:0] {ACC_IDLE = 2'b00, ACC_WAIT = 2'b01} acc_st_type;

  typedef struct packed {
    logic       ais_lop;
    logic       concat;
    logic       j1_v;
    logic [5:0] j1_sts;
    logic [7:0] j1;
    logic       spe_v;
    logic [7:0] spe;
    logic       b3_v;
    logic [7:0] b3;
  } chan_in_type;

  typedef struct packed {
    logic [15:0]   tctl;
    logic [15:0]   maint;
    logic [3:0]    alm;
    logic [5:0]    idx;
    logic          diff;
    logic          prev_cr;
    logic          stab;
    logic [3:0]    mcnt;
    logic [2:0]    wpos;
    logic [2:0]    wmat;
    logic          mism;
    logic [7:0]    bacc;
    logic [7:0]    bprev;
    logic [15:0]   cv;
    logic [15:0]   cv_last;
    logic [13:0]   sfc;
    logic          sf;
    logic          arm;
    drop_code_type code;
  } ch_type;

  typedef struct packed {
    ch_type [NCH-1:0]     ch;
    logic [15:0]          acc_ctl;
    acc_st_type           acc_st;
    logic                 acc_done;
    logic [15:0]          pre;
    logic [3:0][15:0]     wlen;
    logic [3:0][15:0]     wnew;
    logic [3:0][15:0]     wcnt;
    logic [7:0][1:0][15:0] thr;
    logic [2:0]           pm;
    logic [15:0]          rdata;
  } st_type;
endpackage
`default_nettype wire

/* rtl/rx_path_trace_bip_monitor.sv */
/*
  Receive path trace and path BIP-8 monitor for four STS-48 streams.
  Assumes the pointer interpreter and register port share CLK_I; the PM
  clock is an asynchronous pin.
*/
`default_nettype none
module rx_path_trace_bip_monitor #(
  parameter int unsigned HALF_MS_CYC_P = rx_pohm_pkg::HALF_MS_CYC
) (
  // clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic                       CE_I,
  input  wire logic                       PM_CLK_I,
  // pointer interpreter side
  input  wire rx_pohm_pkg::chan_in_type [3:0] CH_I,
  // drop side
  output var  rx_pohm_pkg::drop_code_type [3:0] DROP_CODE_O,
  output var  logic [3:0]                 SF_O,
  output var  logic [3:0]                 MISM_O,
  // register port
  input  wire logic [15:0]                UP_ADDR_I,
  input  wire logic [15:0]                UP_WDATA_I,
  input  wire logic                       UP_WR_I,
  input  wire logic                       UP_RD_I,
  output var  logic [15:0]                UP_RDATA_O
);
  import rx_pohm_pkg::*;

  st_type       st_r;
  st_type       st_nxt;
  logic [8:0]   mem [NCH][2][64];
  logic [15:0]  buff [32];
  logic [NCH-1:0]      jw;
  logic [NCH-1:0][5:0] jidx;
  logic [NCH-1:0][7:0] jdat;
  logic [NCH-1:0]      mend;
  logic [NCH-1:0][3:0] nerr;
  logic [3:0]   wend;
  logic         xfer;
  logic         pm_edge;
  logic         tick;
  logic [1:0]   ach;
  logic         xsl;

  function automatic logic [2:0] ch_hit(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    ch_hit = {(d[15:10] == 6'h00) && (d[7:0] == 8'h00), d[9:8]};
  endfunction

  function automatic logic [3:0] popcnt(input logic [7:0] e);
    popcnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      popcnt = popcnt + {3'h0, e[i]};
    end
  endfunction

  assign ach = st_r.acc_ctl[1:0];
  assign xsl = st_r.acc_ctl[AC_KIND] ? ~st_r.ch[ach].stab : st_r.ch[ach].stab;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0]  h;
    logic [15:0] d;
    logic        go;
    logic [5:0]  ix;
    logic        df;
    logic [3:0]  ev;
    logic [7:0]  e;
    logic [15:0] r;
    logic [13:0] t;
    logic [13:0] lim;
    logic [14:0] sum;
    logic [13:0] cn;
    logic [16:0] cv_sum;
    logic [2:0]  pos;
    logic [2:0]  mat;
    st_nxt = st_r;
    jw = '0;
    jidx = '0;
    jdat = '0;
    mend = '0;
    nerr = '0;
    wend = '0;
    xfer = 1'b0;
    go = 1'b0;
    h = 3'h0;
    d = 16'h0000;
    ix = 6'h00;
    df = 1'b0;
    ev = 4'h0;
    e = 8'h00;
    r = 16'h0000;
    t = 14'h0000;
    lim = 14'h0000;
    sum = 15'h0000;
    cn = 14'h0000;
    cv_sum = 17'h00000;
    pos = 3'h0;
    mat = 3'h0;
    pm_edge = st_r.pm[1] & ~st_r.pm[2];
    tick = st_r.pre == 16'(HALF_MS_CYC_P - 1);
    if (CE_I) begin
      st_nxt.pm = {st_r.pm[1:0], PM_CLK_I};
      st_nxt.pre = tick ? 16'h0000 : 16'(st_r.pre + 16'h0001);
      for (int w = 0; w < 4; w++) begin
        if (tick) begin
          if ({1'b0, st_r.wcnt[w]} + 17'h00001 >= {1'b0, st_r.wlen[w]}) begin
            wend[w] = 1'b1;
            st_nxt.wcnt[w] = 16'h0000;
            st_nxt.wlen[w] = st_r.wnew[w];
          end else begin
            st_nxt.wcnt[w] = 16'(st_r.wcnt[w] + 16'h0001);
          end
        end
      end
      // register writes, before event sets so a set wins
      if (UP_WR_I) begin
        if (UP_ADDR_I == A_ACC_CTL) begin
          st_nxt.acc_ctl = UP_WDATA_I;
        end else if (UP_ADDR_I == A_ACC_DONE) begin
          if (UP_WDATA_I[0]) st_nxt.acc_done = 1'b0;
        end else if (UP_ADDR_I == A_ACC_GO) begin
          go = UP_WDATA_I == ACC_GO;
        end else if (ch_hit(UP_ADDR_I, A_TRC_CTL) >= 3'h4) begin
          h = ch_hit(UP_ADDR_I, A_TRC_CTL);
          st_nxt.ch[h[1:0]].tctl = UP_WDATA_I;
        end else if (ch_hit(UP_ADDR_I, A_MAINT) >= 3'h4) begin
          h = ch_hit(UP_ADDR_I, A_MAINT);
          st_nxt.ch[h[1:0]].maint = UP_WDATA_I;
        end else if (ch_hit(UP_ADDR_I, A_ALARM) >= 3'h4) begin
          h = ch_hit(UP_ADDR_I, A_ALARM);
          st_nxt.ch[h[1:0]].alm = st_r.ch[h[1:0]].alm & ~UP_WDATA_I[3:0];
        end else if (16'(UP_ADDR_I - A_SF_SET) < 16'h0010) begin
          d = 16'(UP_ADDR_I - A_SF_SET);
          st_nxt.thr[d[3:1]][d[0]] = (d[3:1] < 3'h2) ?
            {UP_WDATA_I[15:14], 5'h00, UP_WDATA_I[8:0]} : UP_WDATA_I;
        end else if (16'(UP_ADDR_I - A_WIN) < 16'h0004) begin
          d = 16'(UP_ADDR_I - A_WIN);
          st_nxt.wnew[d[1:0]] = UP_WDATA_I;
        end
      end
      for (int c = 0; c < NCH; c++) begin
        ev = 4'h0;
        // trace message, gated by alarm indication or pointer loss
        if (!CH_I[c].ais_lop && CH_I[c].j1_v &&
            CH_I[c].j1_sts == st_r.ch[c].tctl[5:0]) begin
          ix = (st_r.ch[c].tctl[TC_SDH] && CH_I[c].j1[7]) ? 6'h00 : st_r.ch[c].idx;
          df = ((ix == 6'h00) ? 1'b0 : st_r.ch[c].diff) |
               (mem[c][st_r.ch[c].stab][ix][7:0] != CH_I[c].j1);
          if (^mem[c][st_r.ch[c].stab][ix]) ev[2] = 1'b1;
          jw[c] = 1'b1;
          jidx[c] = ix;
          jdat[c] = CH_I[c].j1;
          mend[c] = st_r.ch[c].tctl[TC_SDH] ? (ix == LAST_SDH) :
                    ((st_r.ch[c].prev_cr && CH_I[c].j1 == CHR_LF) || ix == LAST_SONET);
          st_nxt.ch[c].prev_cr = CH_I[c].j1 == CHR_CR;
          st_nxt.ch[c].diff = df;
          st_nxt.ch[c].idx = mend[c] ? 6'h00 : 6'(ix + 6'h01);
          if (mend[c]) begin
            if (st_r.ch[c].tctl[TC_VAL]) begin
              st_nxt.ch[c].mism = 1'b0;
              if (!df) begin
                st_nxt.ch[c].mcnt = 4'h0;
              end else if (st_r.ch[c].mcnt == NEW_CNT - 4'h1) begin
                st_nxt.ch[c].stab = ~st_r.ch[c].stab;
                st_nxt.ch[c].mcnt = 4'h0;
                ev[1] = 1'b1;
              end else begin
                st_nxt.ch[c].mcnt = 4'(st_r.ch[c].mcnt + 4'h1);
              end
            end else if (!st_r.ch[c].mism) begin
              st_nxt.ch[c].wpos = 3'h0;
              st_nxt.ch[c].wmat = 3'h0;
              if (!df) begin
                st_nxt.ch[c].mcnt = 4'h0;
              end else if (st_r.ch[c].mcnt == MISM_CNT - 4'h1) begin
                st_nxt.ch[c].mism = 1'b1;
                st_nxt.ch[c].mcnt = 4'h0;
                ev[0] = 1'b1;
              end else begin
                st_nxt.ch[c].mcnt = 4'(st_r.ch[c].mcnt + 4'h1);
              end
            end else begin
              pos = 3'(st_r.ch[c].wpos + 3'h1);
              mat = 3'(st_r.ch[c].wmat + {2'h0, ~df});
              st_nxt.ch[c].wpos = (pos == CLR_WIN) ? 3'h0 : pos;
              st_nxt.ch[c].wmat = (pos == CLR_WIN) ? 3'h0 : mat;
              if (pos == CLR_WIN && mat >= CLR_MATCH) begin
                st_nxt.ch[c].mism = 1'b0;
              end
            end
          end
        end
        // path BIP-8
        if (!CH_I[c].ais_lop && CH_I[c].spe_v) begin
          st_nxt.ch[c].bacc = st_r.ch[c].bacc ^ CH_I[c].spe;
        end
        if (!CH_I[c].ais_lop && CH_I[c].b3_v) begin
          e = CH_I[c].b3 ^ st_r.ch[c].bprev;
          nerr[c] = st_r.ch[c].maint[MT_BLK] ? {3'h0, |e} : popcnt(e);
          st_nxt.ch[c].bprev = st_r.ch[c].bacc;
          st_nxt.ch[c].bacc = 8'h00;
        end
        cv_sum = {1'b0, st_r.ch[c].cv} + {13'h0000, nerr[c]};
        if (pm_edge) begin
          st_nxt.ch[c].cv_last = st_r.ch[c].cv;
          st_nxt.ch[c].cv = 16'h0000;
        end else begin
          st_nxt.ch[c].cv = cv_sum[16] ? CV_MAX : cv_sum[15:0];
        end
        // signal fail
        r = st_r.thr[st_r.ch[c].maint[MT_SET+:3]][st_r.ch[c].sf];
        t = r[13:0];
        lim = CH_I[c].concat ? SF14_MAX : SF9_MAX;
        sum = {1'b0, st_r.ch[c].sfc} + {11'h000, nerr[c]};
        cn = (sum > {1'b0, lim}) ? lim : sum[13:0];
        if (!st_r.ch[c].sf) begin
          if (cn >= t) begin
            st_nxt.ch[c].sf = 1'b1;
            st_nxt.ch[c].arm = 1'b0;
            st_nxt.ch[c].sfc = 14'h0000;
            ev[3] = 1'b1;
          end else begin
            st_nxt.ch[c].sfc = wend[r[15:14]] ? 14'h0000 : cn;
          end
        end else if (wend[r[15:14]]) begin
          if (st_r.ch[c].arm && cn < t) st_nxt.ch[c].sf = 1'b0;
          st_nxt.ch[c].arm = 1'b1;
          st_nxt.ch[c].sfc = 14'h0000;
        end else begin
          st_nxt.ch[c].sfc = cn;
        end
        st_nxt.ch[c].code = st_nxt.ch[c].sf ? DC_SF :
                            (st_r.ch[c].maint[MT_SD] ? DC_SD : DC_NONE);
        if (c == int'(ach) && st_r.acc_st == ACC_WAIT && mend[c] && !st_r.acc_ctl[AC_WR]) begin
          for (int i = 0; i < 64; i++) begin
            if (^mem[c][xsl][i]) ev[2] = 1'b1;
          end
        end
        st_nxt.ch[c].alm = st_nxt.ch[c].alm | (ev & ~st_r.ch[c].tctl[TC_MSK+:4]);
      end
      // message buffer access
      case (st_r.acc_st)
        ACC_IDLE: begin
          if (go) st_nxt.acc_st = ACC_WAIT;
        end
        ACC_WAIT: begin
          if (mend[ach]) begin
            xfer = 1'b1;
            st_nxt.acc_st = ACC_IDLE;
            st_nxt.acc_done = 1'b1;
          end
        end
        default: st_nxt.acc_st = ACC_IDLE;
      endcase
      // register reads
      if (UP_RD_I) begin
        if (UP_ADDR_I == A_ACC_CTL) begin
          st_nxt.rdata = st_r.acc_ctl;
        end else if (UP_ADDR_I == A_ACC_DONE) begin
          st_nxt.rdata = {15'h0000, st_r.acc_done};
        end else if (UP_ADDR_I == A_ACC_GO) begin
          st_nxt.rdata = {15'h0000, st_r.acc_st == ACC_WAIT};
        end else if (16'(UP_ADDR_I - A_BUF) < 16'h0020) begin
          st_nxt.rdata = buff[5'(UP_ADDR_I - A_BUF)];
        end else if (ch_hit(UP_ADDR_I, A_TRC_CTL) >= 3'h4) begin
          st_nxt.rdata = st_r.ch[UP_ADDR_I[9:8]].tctl;
        end else if (ch_hit(UP_ADDR_I, A_MAINT) >= 3'h4) begin
          st_nxt.rdata = st_r.ch[UP_ADDR_I[9:8]].maint;
        end else if (ch_hit(UP_ADDR_I, A_CV) >= 3'h4) begin
          st_nxt.rdata = st_r.ch[UP_ADDR_I[9:8]].cv_last;
        end else if (ch_hit(UP_ADDR_I, A_ALARM) >= 3'h4) begin
          st_nxt.rdata = {6'h00, st_r.ch[UP_ADDR_I[9:8]].sf, st_r.ch[UP_ADDR_I[9:8]].mism,
                          4'h0, st_r.ch[UP_ADDR_I[9:8]].alm};
        end else if (16'(UP_ADDR_I - A_SF_SET) < 16'h0010) begin
          d = 16'(UP_ADDR_I - A_SF_SET);
          st_nxt.rdata = st_r.thr[d[3:1]][d[0]];
        end else if (16'(UP_ADDR_I - A_WIN) < 16'h0004) begin
          st_nxt.rdata = st_r.wnew[UP_ADDR_I[1:0] - 2'h2];
        end else begin
          st_nxt.rdata = 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= '0;
      for (int s = 0; s < 8; s++) begin
        st_r.thr[s][0] <= SF_THR_RST[s][0];
        st_r.thr[s][1] <= SF_THR_RST[s][1];
      end
      for (int w = 0; w < 4; w++) begin
        st_r.wlen[w] <= WIN_RST[w];
        st_r.wnew[w] <= WIN_RST[w];
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // message memories and shared access buffer
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mem <= '{default: '0};
      buff <= '{default: '0};
    end else if (CE_I) begin
      for (int c = 0; c < NCH; c++) begin
        if (jw[c]) mem[c][~st_r.ch[c].stab][jidx[c]] <= {^jdat[c], jdat[c]};
      end
      if (xfer) begin
        for (int i = 0; i < 64; i++) begin
          if (st_r.acc_ctl[AC_WR]) begin
            mem[ach][xsl][i] <= {^buff[i/2][8*(1-i%2)+:8], buff[i/2][8*(1-i%2)+:8]};
          end else begin
            buff[i/2][8*(1-i%2)+:8] <= mem[ach][xsl][i][7:0];
          end
        end
      end
      if (UP_WR_I && 16'(UP_ADDR_I - A_BUF) < 16'h0020) begin
        buff[5'(UP_ADDR_I - A_BUF)] <= UP_WDATA_I;
      end
    end
  end

  always_comb begin
    UP_RDATA_O = st_r.rdata;
    for (int c = 0; c < NCH; c++) begin
      DROP_CODE_O[c] = st_r.ch[c].code;
      SF_O[c] = st_r.ch[c].sf;
      MISM_O[c] = st_r.ch[c].mism;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  cv_saturate_a: assert property (CE_I && !pm_edge && st_r.ch[0].cv == CV_MAX |=> st_r.ch[0].cv == CV_MAX)
    else $error("cv counter wrapped");
  pm_snapshot_a: assert property (CE_I && pm_edge |=> st_r.ch[0].cv == 16'h0000 &&
    st_r.ch[0].cv_last == $past(st_r.ch[0].cv)) else $error("pm snapshot wrong");
  mism_declare_a: assert property ($rose(st_r.ch[0].mism) |-> $past(st_r.ch[0].mcnt) == 4'h9)
    else $error("mismatch declared early");
  sf_drop_a: assert property (st_r.ch[0].sf |-> DROP_CODE_O[0] == DC_SF)
    else $error("signal fail code missing");
  sf_narrow_a: assert property (CE_I && !CH_I[0].concat && st_r.ch[0].sfc <= SF9_MAX |=>
    st_r.ch[0].sfc <= SF9_MAX) else $error("narrow counter overflow");
  acc_done_a: assert property (CE_I && xfer |=> st_r.acc_done && st_r.acc_st == ACC_IDLE)
    else $error("access not completed");
  win_hold_a: assert property (CE_I && !wend[0] |=> st_r.wlen[0] == $past(st_r.wlen[0]))
    else $error("window length changed mid window");
  inhibit_a: assert property (CE_I && CH_I[0].ais_lop |=> st_r.ch[0].cv <= $past(st_r.ch[0].cv))
    else $error("counting while inhibited");
  new_msg_a: assert property (CE_I && $changed(st_r.ch[0].stab) && !$past(st_r.ch[0].tctl[TC_MSK+1]) |->
    st_r.ch[0].alm[1]) else $error("new message not latched");

  xfer_c: cover property (CE_I && xfer);
  sf_rise_c: cover property ($rose(st_r.ch[0].sf));
  sf_fall_c: cover property ($fell(st_r.ch[0].sf));
  mism_c: cover property ($rose(st_r.ch[0].mism));
endmodule
`default_nettype wire

/* sim/ptr_interp_model.sv */
/*
  Behavioural receive pointer interpreter feeding the trace/BIP monitor.
  Assumes the bench calls its tasks from one process, clocked by CLK_I.
*/
`default_nettype none
module ptr_interp_model (
  // clock
  input  wire logic                          CLK_I,
  // stream outputs
  output var  rx_pohm_pkg::chan_in_type [3:0] CH_O
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_pohm_pkg::*;
  initial begin
    CH_O = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one byte: kind 0 trace, 1 payload, 2 parity; data inverted once released
  task automatic put(input int c, input int kind, input logic [7:0] d);
    @(posedge CLK_I);
    CH_O[c].j1_v  <= (kind == 0);
    CH_O[c].spe_v <= (kind == 1);
    CH_O[c].b3_v  <= (kind == 2);
    CH_O[c].j1    <= d;
    CH_O[c].spe   <= d;
    CH_O[c].b3    <= d;
    @(posedge CLK_I);
    CH_O[c].j1_v  <= 1'b0;
    CH_O[c].spe_v <= 1'b0;
    CH_O[c].b3_v  <= 1'b0;
    CH_O[c].j1    <= ~d;
    CH_O[c].spe   <= ~d;
    CH_O[c].b3    <= ~d;
  endtask
  // alarm indication / pointer loss level for one stream
  task automatic hold_off(input int c, input logic v);
    @(posedge CLK_I);
    CH_O[c].ais_lop <= v;
  endtask
endmodule
`default_nettype wire

/* sim/tb_rx_path_trace_bip_monitor.sv */
/*
  Self-checking bench for the trace/BIP monitor, channel 0.
  Assumes the design package and the pointer interpreter model.
*/
`default_nettype none
module tb_rx_path_trace_bip_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_pohm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pm_clk = 1'b0, up_wr = 1'b0, up_rd = 1'b0;
  logic [15:0] up_addr = '0, up_wdata = '0, up_rdata;
  logic [3:0] sf, mism;
  drop_code_type [3:0] drop;
  chan_in_type [3:0] ch;
  int failures = 0, compares = 0;
  always #10 clk = ~clk;
  ptr_interp_model i_far (.CLK_I(clk), .CH_O(ch));
  rx_path_trace_bip_monitor #(.HALF_MS_CYC_P(4)) i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .PM_CLK_I(pm_clk), .CH_I(ch), .DROP_CODE_O(drop), .SF_O(sf), .MISM_O(mism), .UP_ADDR_I(up_addr),
    .UP_WDATA_I(up_wdata), .UP_WR_I(up_wr), .UP_RD_I(up_rd), .UP_RDATA_O(up_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    up_addr  <= a;
    up_wdata <= d;
    up_wr    <= 1'b1;
    @(posedge clk);
    up_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    up_addr <= a;
    up_rd   <= 1'b1;
    @(posedge clk);
    up_rd   <= 1'b0;
    @(posedge clk);
    #1 d = up_rdata;
  endtask
  task automatic pm_tick();
    pm_clk <= 1'b1;
    repeat (5) @(posedge clk);
    pm_clk <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  // marker bit only on byte 0 of an SDH message
  function automatic logic [7:0] mb(input int i, input bit bad);
    return (i == 0) ? 8'h80 : ((bad && i == 1) ? 8'h55 : 8'h40 + 8'(i));
  endfunction
  task automatic msg(input bit bad);
    for (int i = 0; i < 16; i++) begin
      i_far.put(0, 0, mb(i, bad));
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] s, input logic [7:0] b3);
    i_far.put(0, 1, s);
    i_far.put(0, 1, s + 8'h01);
    i_far.put(0, 2, b3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] d;
    rd(A_SF_SET, d);
    chk("detect set 0", 16'h40CF, d);
    rd(A_SF_SET + 16'h0001, d);
    chk("clear set 0", 16'h8113, d);
    rd(16'h4FFF, d);
    chk("unmapped read", 16'h0000, d);
    wr(A_ACC_GO, 16'h0002);
    rd(A_ACC_GO, d);
    chk("start ignored", 16'h0000, d);
  endtask
  task automatic t_bip();
    logic [15:0] d;
    frame(8'h10, 8'h00);
    pm_tick();
    frame(8'h20, 8'h10 ^ 8'h11 ^ 8'h03);
    frame(8'h30, 8'h20 ^ 8'h21);
    pm_tick();
    rd(A_CV, d);
    chk("bit mode cv", 16'h0002, d);
    wr(A_MAINT, 16'h0001);
    frame(8'h40, 8'h30 ^ 8'h31 ^ 8'h07);
    frame(8'h50, 8'h40 ^ 8'h41);
    pm_tick();
    rd(A_CV, d);
    chk("block mode cv", 16'h0001, d);
    i_far.hold_off(0, 1'b1);
    frame(8'h70, 8'hFF);
    i_far.hold_off(0, 1'b0);
    pm_tick();
    rd(A_CV, d);
    chk("inhibited cv", 16'h0000, d);
    wr(A_MAINT, 16'h0000);
  endtask
  task automatic t_trace();
    logic [15:0] d;
    wr(A_TRC_CTL, 16'h0040);
    for (int k = 0; k < 8; k++) begin
      wr(A_BUF + 16'(k), {mb(2 * k, 0), mb(2 * k + 1, 0)});
    end
    wr(A_ACC_CTL, 16'h0008);
    wr(A_ACC_GO, ACC_GO);
    msg(0);
    rd(A_ACC_DONE, d);
    chk("access done", 16'h0001, d & 16'h0001);
    wr(A_ACC_DONE, 16'h0001);
    rd(A_ACC_DONE, d);
    chk("done cleared", 16'h0000, d & 16'h0001);
    // loading message met an empty memory; one match restarts the run
    msg(0);
    chk("mismatch idle", 16'h0000, {15'h0, mism[0]});
    for (int n = 1; n <= 10; n++) begin
      msg(1);
      chk("mismatch state", {15'h0, n == 10}, {15'h0, mism[0]});
    end
    for (int n = 1; n <= 5; n++) begin
      msg(n == 5);
    end
    chk("mismatch cleared", 16'h0000, {15'h0, mism[0]});
    rd(A_ALARM, d);
    chk("mismatch latched", 16'h0001, d & 16'h0101);
    wr(A_ALARM, 16'h0001);
    rd(A_ALARM, d);
    chk("mismatch w1c", 16'h0000, d & 16'h0001);
  endtask
  task automatic t_valid();
    logic [15:0] d;
    wr(A_TRC_CTL, 16'h00C0);
    for (int n = 1; n <= 10; n++) begin
      msg(1);
      rd(A_ALARM, d);
      chk("new message", {14'h0, n == 10, 1'b0}, d & 16'h0002);
    end
    wr(A_ACC_CTL, 16'h0000);
    wr(A_ACC_GO, ACC_GO);
    msg(1);
    rd(A_BUF, d);
    chk("stable read back", {mb(0, 1), mb(1, 1)}, d);
  endtask
  task automatic t_fail();
    logic [15:0] d;
    wr(A_MAINT, 16'h0010);
    repeat (2) @(posedge clk);
    chk("forced degrade", 16'(DC_SD), 16'(drop[0]));
    wr(A_MAINT, 16'h0000);
    wr(A_SF_SET, 16'h0001);
    frame(8'h60, 8'h50 ^ 8'h51 ^ 8'h01);
    repeat (2) @(posedge clk);
    chk("fail state", 16'h0001, {15'h0, sf[0]});
    chk("fail code", 16'(DC_SF), 16'(drop[0]));
    rd(A_ALARM, d);
    chk("fail alarm", 16'h0208, d & 16'h0208);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    failures++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_bip();
    t_trace();
    t_valid();
    t_fail();
    close_out();
  end
endmodule
`default_nettype wire
